// ===== common/ovp_pkg.sv
// Package of constants and types for the overvoltage protection stages.
`default_nettype none
package ovp_pkg;
    // ----------------------------------------
    // Sizes and stage capabilities
    // ----------------------------------------
    localparam int NSTG = 6;
    localparam logic [5:0] INV_CAP = 6'h0b;
    localparam logic [5:0] HOLD_CAP = 6'h09;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [3:0] OFS_THR = 4'h0;
    localparam logic [3:0] OFS_DLY = 4'h4;
    localparam logic [3:0] OFS_CFG = 4'h8;
    localparam logic [3:0] OFS_MUL = 4'hc;
    localparam logic [7:0] OFS_STAT = 8'h60;
    localparam logic [7:0] OFS_CTRL = 8'h64;
    localparam logic [7:0] OFS_HOLD_PH = 8'h68;
    localparam logic [7:0] OFS_HOLD_E = 8'h6c;
    localparam int CFG_INV_BIT = 0;
    localparam int CFG_CURVE_LSB = 1;
    localparam int CTRL_RST_PH = 0;
    localparam int CTRL_RST_E = 1;
    localparam int STAT_TRIP_LSB = 6;
    localparam int STAT_TICK_LOST = 12;
    localparam logic [15:0] RST_THR = 16'hffff;
    localparam logic [19:0] RST_DLY = 20'h00000;
    localparam logic [15:0] RST_MUL = 16'h0064;
    localparam logic [19:0] RST_HOLD = 20'h00000;
    localparam logic [15:0] RTM_MIN = 16'h0002;
    localparam logic [15:0] RTM_MAX_IEC = 16'h0096;
    localparam logic [15:0] RTM_MAX_US = 16'h2710;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int DET_TIME_MS = 20;
    localparam int DET_CYC_DFLT = DET_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TICK_PERIOD_US = 1000;
    localparam int HOLD_MAX_S = 600;
    localparam logic [19:0] HOLD_MAX_TICKS = 20'(HOLD_MAX_S * 1000000 / TICK_PERIOD_US);
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [3:0] {
        CRV_IEC_SI, CRV_IEC_VI, CRV_IEC_EI, CRV_IEC_LTI, CRV_FR_STI, CRV_UK_RECT,
        CRV_IEEE_MI, CRV_IEEE_VI, CRV_IEEE_EI, CRV_US_CO2P20, CRV_US_CO2P40,
        CRV_US_CO8, CRV_RI, CRV_BNP, CRV_RXIDG, CRV_SPARE
    } ovp_curve_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_TRIP = 2'b11, ST_HOLD = 2'b10
    } ovp_st_t;
    typedef struct packed {
        logic [15:0] thr;
        logic [19:0] dly;
        logic inv;
        ovp_curve_t curve;
        logic [15:0] tms;
        logic [15:0] rtm;
    } ovp_cfg_t;
    typedef struct packed {
        ovp_st_t st;
        logic [31:0] acc;
        logic [31:0] hcnt;
    } ovp_stg_t;
    typedef struct packed {
        ovp_cfg_t [NSTG-1:0] cfg;
        ovp_stg_t [NSTG-1:0] stg;
        logic [1:0] rst_type;
        logic [19:0] hold_ph;
        logic [19:0] hold_e;
        logic [NSTG-1:0] blk_s1;
        logic [NSTG-1:0] blk_s2;
        logic [NSTG-1:0] start;
        logic [NSTG-1:0] trip;
        logic [31:0] prdata;
        logic [31:0] tick_cnt;
        logic tick_lost;
    } ovp_state_t;
    // Reset constant of the IEC SI, VI and EI, IEEE and US curves in hundredths of a second; zero for the rest.
    function automatic logic [13:0] curve_tr(input ovp_curve_t c);
        case (c)
            CRV_IEC_SI: curve_tr = 14'h04ba;
            CRV_IEC_VI: curve_tr = 14'h10e0;
            CRV_IEC_EI: curve_tr = 14'h1f40;
            CRV_IEEE_MI: curve_tr = 14'h01ea;
            CRV_IEEE_VI: curve_tr = 14'h0870;
            CRV_IEEE_EI: curve_tr = 14'h0b5e;
            CRV_US_CO2P20: curve_tr = 14'h00e2;
            CRV_US_CO2P40: curve_tr = 14'h00e2;
            CRV_US_CO8: curve_tr = 14'h0253;
            default: curve_tr = 14'h0000;
        endcase
    endfunction
endpackage
`default_nettype wire

// ===== hw/ovp_stages.sv
// Phase and earth overvoltage protection stages with an APB register slave.
`timescale 1ns/100ps
`default_nettype none
module ovp_stages #(
    parameter int DET_CYC = ovp_pkg::DET_CYC_DFLT
) (
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SAMPLE_TICK,
    input wire logic [2:0][15:0] PHASE_V,
    input wire logic [15:0] EARTH_V,
    input wire logic [ovp_pkg::NSTG-1:0] STAGE_BLOCK,
    output logic [ovp_pkg::NSTG-1:0] STAGE_START,
    output logic [ovp_pkg::NSTG-1:0] STAGE_TRIP,
    output logic TICK_LOST
);
    import ovp_pkg::*;

    ovp_state_t s_q;
    ovp_state_t s_d;
    logic [NSTG-1:0] above_w;
    logic [NSTG-1:0] below95_w;
    logic [15:0] vmax;
    logic wr_en;
    logic rd_map;

    // ----------------------------------------
    // Register helpers
    // ----------------------------------------
    function automatic logic [15:0] rtm_eff(input ovp_cfg_t c);
        logic [15:0] hi;
        hi = (c.curve >= CRV_IEEE_MI && c.curve <= CRV_US_CO8) ? RTM_MAX_US : RTM_MAX_IEC;
        if (c.rtm < RTM_MIN) begin
            rtm_eff = RTM_MIN;
        end else if (c.rtm > hi) begin
            rtm_eff = hi;
        end else begin
            rtm_eff = c.rtm;
        end
    endfunction

    function automatic logic [19:0] hold_clamp(input logic [19:0] v);
        hold_clamp = (v > HOLD_MAX_TICKS) ? HOLD_MAX_TICKS : v;
    endfunction

    assign PREADY = 1'b1;
    assign PRDATA = s_q.prdata;
    assign STAGE_START = s_q.start;
    assign STAGE_TRIP = s_q.trip;
    assign TICK_LOST = s_q.tick_lost;
    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_map = (PADDR[7:4] < 4'(NSTG)) || (PADDR[7:4] == OFS_STAT[7:4]);
    assign PSLVERR = PSEL && PENABLE && (!rd_map || PADDR[1:0] != 2'b00);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [15:0] v;
        logic blk;
        logic inv_en;
        logic rst_inv;
        logic [31:0] op_inc;
        logic [31:0] op_tgt;
        logic [31:0] h_inc;
        logic [31:0] h_tgt;
        logic [31:0] acc_n;
        logic [31:0] hcnt_n;
        logic [3:0] ix;
        v = 16'h0000;
        blk = 1'b0;
        inv_en = 1'b0;
        rst_inv = 1'b0;
        op_inc = 32'h0;
        op_tgt = 32'h0;
        h_inc = 32'h0;
        h_tgt = 32'h0;
        acc_n = 32'h0;
        hcnt_n = 32'h0;
        ix = PADDR[7:4];
        s_d = s_q;
        above_w = '0;
        below95_w = '0;
        // The highest phase decides, so one phase above threshold is enough to pick up.
        vmax = PHASE_V[0];
        if (PHASE_V[1] > vmax) begin
            vmax = PHASE_V[1];
        end
        if (PHASE_V[2] > vmax) begin
            vmax = PHASE_V[2];
        end
        // Blocking arrives from a pin, so it passes two flip-flops before any stage reads it.
        s_d.blk_s1 = STAGE_BLOCK;
        s_d.blk_s2 = s_q.blk_s1;
        // Ticks slower than the detection bound would stretch operate times unnoticed.
        if (SAMPLE_TICK) begin
            s_d.tick_cnt = 32'h0;
        end else if (s_q.tick_cnt != 32'(DET_CYC)) begin
            s_d.tick_cnt = s_q.tick_cnt + 32'h1;
        end
        for (int i = 0; i < NSTG; i++) begin
            v = (i < 3) ? vmax : EARTH_V;
            blk = s_q.blk_s2[i];
            inv_en = s_q.cfg[i].inv && INV_CAP[i];
            rst_inv = inv_en && s_q.rst_type[(i < 3) ? CTRL_RST_PH : CTRL_RST_E];
            above_w[i] = v > s_q.cfg[i].thr;
            below95_w[i] = (21'(v) * 21'd20) < (21'(s_q.cfg[i].thr) * 21'd19);
            // Operate progress grows with the excess, giving an inverse-time delay.
            op_inc = inv_en ? 32'(v - s_q.cfg[i].thr) : 32'h1;
            op_tgt = inv_en ? {8'h00, s_q.cfg[i].tms, 8'h00} : 32'(s_q.cfg[i].dly);
            h_inc = rst_inv ? 32'(s_q.cfg[i].thr - v) : 32'h1;
            h_tgt = rst_inv ? 32'(rtm_eff(s_q.cfg[i]) * 30'(curve_tr(s_q.cfg[i].curve)))
                            : 32'((i < 3) ? s_q.hold_ph : s_q.hold_e);
            acc_n = s_q.stg[i].acc + op_inc;
            hcnt_n = s_q.stg[i].hcnt + h_inc;
            if (SAMPLE_TICK) begin
                case (s_q.stg[i].st)
                    ST_IDLE: begin
                        if (above_w[i] && !blk) begin
                            s_d.stg[i].st = (op_inc >= op_tgt) ? ST_TRIP : ST_RUN;
                            s_d.stg[i].acc = op_inc;
                            s_d.stg[i].hcnt = 32'h0;
                        end
                    end
                    ST_RUN, ST_HOLD: begin
                        if (blk) begin
                            s_d.stg[i] = s_q.stg[i];
                        end else if (above_w[i]) begin
                            s_d.stg[i].acc = acc_n;
                            s_d.stg[i].hcnt = 32'h0;
                            s_d.stg[i].st = (acc_n >= op_tgt) ? ST_TRIP : ST_RUN;
                        end else if (!HOLD_CAP[i]) begin
                            s_d.stg[i].st = ST_IDLE;
                            s_d.stg[i].acc = 32'h0;
                        end else if (!below95_w[i]) begin
                            s_d.stg[i].st = ST_HOLD;
                            s_d.stg[i].hcnt = 32'h0;
                        end else if (hcnt_n >= h_tgt) begin
                            s_d.stg[i].st = ST_IDLE;
                            s_d.stg[i].acc = 32'h0;
                            s_d.stg[i].hcnt = 32'h0;
                        end else begin
                            s_d.stg[i].st = ST_HOLD;
                            s_d.stg[i].hcnt = hcnt_n;
                        end
                    end
                    ST_TRIP: begin
                        if (!above_w[i]) begin
                            s_d.stg[i].st = ST_IDLE;
                            s_d.stg[i].acc = 32'h0;
                            s_d.stg[i].hcnt = 32'h0;
                        end
                    end
                    default: begin
                        s_d.stg[i].st = ST_IDLE;
                    end
                endcase
            end
            s_d.start[i] = (s_d.stg[i].st == ST_RUN) || (s_d.stg[i].st == ST_TRIP);
            s_d.trip[i] = (s_d.stg[i].st == ST_TRIP) && above_w[i] && !blk;
        end
        // Register writes take effect at the access edge.
        if (wr_en && PADDR[1:0] == 2'b00) begin
            if (ix < 4'(NSTG)) begin
                case (PADDR[3:0])
                    OFS_THR: s_d.cfg[ix].thr = PWDATA[15:0];
                    OFS_DLY: s_d.cfg[ix].dly = PWDATA[19:0];
                    OFS_CFG: begin
                        s_d.cfg[ix].inv = PWDATA[CFG_INV_BIT];
                        s_d.cfg[ix].curve = ovp_curve_t'(PWDATA[CFG_CURVE_LSB +: 4]);
                    end
                    OFS_MUL: begin
                        s_d.cfg[ix].tms = PWDATA[15:0];
                        s_d.cfg[ix].rtm = PWDATA[31:16];
                    end
                    default: s_d.cfg[ix] = s_q.cfg[ix];
                endcase
            end else begin
                case (PADDR)
                    OFS_STAT: begin
                        // A lost tick seen in the clearing cycle stays set.
                        if (PWDATA[STAT_TICK_LOST]) begin
                            s_d.tick_lost = 1'b0;
                        end
                    end
                    OFS_CTRL: s_d.rst_type = PWDATA[1:0];
                    OFS_HOLD_PH: s_d.hold_ph = hold_clamp(PWDATA[19:0]);
                    OFS_HOLD_E: s_d.hold_e = hold_clamp(PWDATA[19:0]);
                    default: s_d.rst_type = s_q.rst_type;
                endcase
            end
        end
        if (!SAMPLE_TICK && s_q.tick_cnt == 32'(DET_CYC - 1)) begin
            s_d.tick_lost = 1'b1;
        end
        // Read data is captured in the setup cycle so the access phase needs no wait.
        if (PSEL && !PENABLE) begin
            s_d.prdata = 32'h0;
            if (ix < 4'(NSTG)) begin
                case (PADDR[3:0])
                    OFS_THR: s_d.prdata = {16'h0000, s_q.cfg[ix].thr};
                    OFS_DLY: s_d.prdata = {12'h000, s_q.cfg[ix].dly};
                    OFS_CFG: s_d.prdata = {25'h0, s_q.stg[ix].st, s_q.cfg[ix].curve, s_q.cfg[ix].inv};
                    OFS_MUL: s_d.prdata = {s_q.cfg[ix].rtm, s_q.cfg[ix].tms};
                    default: s_d.prdata = 32'h0;
                endcase
            end else begin
                case (PADDR)
                    OFS_STAT: s_d.prdata = {19'h0, s_q.tick_lost, s_q.trip, s_q.start};
                    OFS_CTRL: s_d.prdata = {30'h0, s_q.rst_type};
                    OFS_HOLD_PH: s_d.prdata = {12'h000, s_q.hold_ph};
                    OFS_HOLD_E: s_d.prdata = {12'h000, s_q.hold_e};
                    default: s_d.prdata = 32'h0;
                endcase
            end
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            // Thresholds reset to full scale so no stage can pick up before software sets it.
            s_q <= '0;
            for (int i = 0; i < NSTG; i++) begin
                s_q.cfg[i].thr <= RST_THR;
                s_q.cfg[i].dly <= RST_DLY;
                s_q.cfg[i].tms <= RST_MUL;
                s_q.cfg[i].rtm <= RST_MUL;
            end
            s_q.hold_ph <= RST_HOLD;
            s_q.hold_e <= RST_HOLD;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_tick_bound: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (!SAMPLE_TICK && s_q.tick_cnt == 32'(DET_CYC - 1)) |=> TICK_LOST)
        else $error("missing tick not flagged");
    a_lost_sticky: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (TICK_LOST && !(wr_en && PADDR == OFS_STAT && PWDATA[STAT_TICK_LOST])) |=> TICK_LOST)
        else $error("lost tick flag dropped without a clear");
    a_hold_range: assert property (@(posedge CORE_CLK) disable iff (SRST)
        s_q.hold_ph <= HOLD_MAX_TICKS && s_q.hold_e <= HOLD_MAX_TICKS)
        else $error("hold delay beyond its range");

    for (genvar gi = 0; gi < NSTG; gi++) begin : g_chk
        a_trip_cond: assert property (@(posedge CORE_CLK) disable iff (SRST)
            STAGE_TRIP[gi] |-> $past(above_w[gi]) && !$past(s_q.blk_s2[gi]))
            else $error("trip without overvoltage or while blocked");
        a_block_trip: assert property (@(posedge CORE_CLK) disable iff (SRST)
            s_q.blk_s2[gi] |=> !STAGE_TRIP[gi])
            else $error("trip raised while blocked");
        a_start_trip: assert property (@(posedge CORE_CLK) disable iff (SRST)
            STAGE_TRIP[gi] |-> STAGE_START[gi])
            else $error("trip without start");
        a_tick_only: assert property (@(posedge CORE_CLK) disable iff (SRST)
            !SAMPLE_TICK |=> s_q.stg[gi] == $past(s_q.stg[gi]))
            else $error("stage timer moved between ticks");
        a_block_freeze: assert property (@(posedge CORE_CLK) disable iff (SRST)
            (s_q.blk_s2[gi] && s_q.stg[gi].st != ST_IDLE && s_q.stg[gi].st != ST_TRIP)
            |=> s_q.stg[gi].acc == $past(s_q.stg[gi].acc))
            else $error("timer moved while blocked");
        a_start_run: assert property (@(posedge CORE_CLK) disable iff (SRST)
            (SAMPLE_TICK && s_q.stg[gi].st == ST_IDLE && above_w[gi] && !s_q.blk_s2[gi])
            |=> STAGE_START[gi] || STAGE_TRIP[gi])
            else $error("start not raised when timer began");
        a_trip_clear: assert property (@(posedge CORE_CLK) disable iff (SRST)
            (SAMPLE_TICK && s_q.stg[gi].st == ST_TRIP && !above_w[gi])
            |=> s_q.stg[gi].st == ST_IDLE && s_q.stg[gi].acc == 32'h0 && !STAGE_TRIP[gi])
            else $error("tripped stage not cleared at once");
        if (!INV_CAP[gi]) begin : g_dt
            a_dt_count: assert property (@(posedge CORE_CLK) disable iff (SRST)
                (SAMPLE_TICK && s_q.stg[gi].st == ST_RUN && above_w[gi] && !s_q.blk_s2[gi])
                |=> s_q.stg[gi].acc == $past(s_q.stg[gi].acc) + 32'h1)
                else $error("definite stage did not count by one");
        end else begin : g_inv
            a_inv_grow: assert property (@(posedge CORE_CLK) disable iff (SRST)
                (SAMPLE_TICK && s_q.stg[gi].st == ST_RUN && above_w[gi] && !s_q.blk_s2[gi])
                |=> s_q.stg[gi].acc > $past(s_q.stg[gi].acc))
                else $error("operate progress did not grow above threshold");
        end
        if (!HOLD_CAP[gi]) begin : g_nohold
            a_no_hold: assert property (@(posedge CORE_CLK) disable iff (SRST)
                (SAMPLE_TICK && s_q.stg[gi].st == ST_RUN && !above_w[gi] && !s_q.blk_s2[gi])
                |=> s_q.stg[gi].st == ST_IDLE ##1 s_q.stg[gi].acc == 32'h0)
                else $error("stage without hold timer kept its delay");
            a_nohold_state: assert property (@(posedge CORE_CLK) disable iff (SRST)
                s_q.stg[gi].st != ST_HOLD)
                else $error("stage without hold timer entered hold");
        end else begin : g_hold
            a_hold_keep: assert property (@(posedge CORE_CLK) disable iff (SRST)
                (SAMPLE_TICK && s_q.stg[gi].st == ST_RUN && !above_w[gi] && !s_q.blk_s2[gi])
                |=> s_q.stg[gi].acc == $past(s_q.stg[gi].acc) || s_q.stg[gi].st == ST_IDLE)
                else $error("hold timer lost accumulated progress");
            a_hold_95: assert property (@(posedge CORE_CLK) disable iff (SRST)
                (SAMPLE_TICK && s_q.stg[gi].st == ST_HOLD && !s_q.blk_s2[gi]
                 && !below95_w[gi] && !above_w[gi])
                |=> s_q.stg[gi].hcnt == 32'h0 && s_q.stg[gi].st == ST_HOLD)
                else $error("hold count not restarted above 95 percent");
            a_hold_exit: assert property (@(posedge CORE_CLK) disable iff (SRST)
                (SAMPLE_TICK && s_q.stg[gi].st == ST_HOLD && !below95_w[gi])
                |=> s_q.stg[gi].st != ST_IDLE)
                else $error("delay cleared without staying below 95 percent");
        end
    end
endmodule // ovp_stages
`default_nettype wire

// ===== dv/ovp_front_end.sv
// Model of the measurement front end that feeds the protection stages.
`timescale 1ns/100ps
`default_nettype none
module ovp_front_end #(
    parameter int TICK_DIV = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic stall,
    input wire logic [15:0] ph_req,
    input wire logic [15:0] e_req,
    output logic tick,
    output logic [2:0][15:0] phase_v,
    output logic [15:0] earth_v
);
    int cnt;
    // ----------------------------------------
    // Periodic tick; a stall stops it so lost ticks can be seen.
    // ----------------------------------------
    always_ff @(posedge clk) begin
        phase_v <= {ph_req, ph_req >> 1, ph_req >> 2};
        earth_v <= e_req;
        if (srst || stall) begin
            cnt <= 0;
            tick <= 1'b0;
        end else begin
            cnt <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
            tick <= (cnt == TICK_DIV - 1);
        end
    end
endmodule // ovp_front_end
`default_nettype wire

// ===== dv/test_ovp_stages.sv
// Self-checking testbench for the overvoltage protection stages.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("unexpected %s exp %h got %h", nm, e, a); end end
module test_ovp_stages;
    import ovp_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stall = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, tick, tick_lost;
    logic [15:0] ph_req = 16'h0000, e_req = 16'h0000, earth_v;
    logic [2:0][15:0] phase_v;
    logic [NSTG-1:0] blk = '0, start, trip;
    int num_errors = 0, total_checks = 0;
    // ----------------------------------------
    // Design, front end and clock
    // ----------------------------------------
    ovp_stages #(.DET_CYC(50)) dut (.CORE_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SAMPLE_TICK(tick), .PHASE_V(phase_v), .EARTH_V(earth_v),
        .STAGE_BLOCK(blk), .STAGE_START(start), .STAGE_TRIP(trip), .TICK_LOST(tick_lost));
    ovp_front_end #(.TICK_DIV(8)) fe (.clk(clk), .srst(srst), .stall(stall), .ph_req(ph_req),
        .e_req(e_req), .tick(tick), .phase_v(phase_v), .earth_v(earth_v));
    initial begin
        forever #20 clk = ~clk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Returns once the outputs decided at the k-th next tick have landed.
    task automatic tick_wait(input int k);
        repeat (k) begin
            do @(posedge clk); while (tick !== 1'b1);
            @(posedge clk);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        apb(1'b0, 8'h0c, 32'h0);
        `CHK("mul reset", 32'h00640064, rd)
        apb(1'b0, 8'h70, 32'h0);
        `CHK("unmapped err", 1'b1, err)
        apb(1'b1, 8'h64, 32'h3);
        apb(1'b0, 8'h64, 32'h0);
        `CHK("reset type", 32'h3, rd)
    endtask
    task automatic t_definite();
        apb(1'b1, 8'h20, 32'h64);
        apb(1'b1, 8'h24, 32'h3);
        apb(1'b1, 8'h28, 32'h1);
        tick_wait(1);
        ph_req <= 16'h00c8;
        tick_wait(1);
        `CHK("start first tick", 2'b10, {start[2], trip[2]})
        tick_wait(1);
        `CHK("no early trip", 1'b0, trip[2])
        tick_wait(1);
        `CHK("trip at delay", 1'b1, trip[2])
        ph_req <= 16'h0000;
        tick_wait(1);
        `CHK("trip clears", 2'b00, {start[2], trip[2]})
    endtask
    task automatic t_block();
        apb(1'b1, 8'h24, 32'h4);
        ph_req <= 16'h00c8;
        tick_wait(2);
        blk <= 6'h04;
        tick_wait(2);
        `CHK("frozen run", 2'b10, {start[2], trip[2]})
        blk <= 6'h00;
        tick_wait(1);
        `CHK("resumed no trip", 1'b0, trip[2])
        tick_wait(1);
        `CHK("resumed trip", 1'b1, trip[2])
        blk <= 6'h04;
        repeat (4) @(posedge clk);
        `CHK("blocked trip", 1'b0, trip[2])
        blk <= 6'h00;
        ph_req <= 16'h0000;
        tick_wait(1);
    endtask
    task automatic t_hold();
        apb(1'b1, 8'h00, 32'h64);
        apb(1'b1, 8'h04, 32'h4);
        apb(1'b1, 8'h10, 32'h64);
        apb(1'b1, 8'h14, 32'h4);
        apb(1'b1, 8'h68, 32'h3);
        ph_req <= 16'h00c8;
        tick_wait(2);
        ph_req <= 16'h0032;
        tick_wait(1);
        `CHK("no hold drop", 1'b0, start[1])
        ph_req <= 16'h00c8;
        tick_wait(2);
        `CHK("pulses add", 2'b01, trip[1:0])
        ph_req <= 16'h0032;
        tick_wait(4);
        ph_req <= 16'h00c8;
        tick_wait(2);
        ph_req <= 16'h0032;
        tick_wait(4);
        ph_req <= 16'h00c8;
        tick_wait(2);
        `CHK("hold expired", 1'b0, trip[0])
        ph_req <= 16'h0000;
        tick_wait(4);
    endtask
    task automatic t_earth();
        apb(1'b1, 8'h30, 32'h64);
        apb(1'b1, 8'h34, 32'h1);
        apb(1'b1, 8'h50, 32'h64);
        e_req <= 16'h00c8;
        tick_wait(1);
        `CHK("earth trip", 3'b101, trip[5:3])
        `CHK("earth start", 3'b101, start[5:3])
    endtask
    task automatic t_inverse();
        apb(1'b1, 8'h18, 32'h1);
        apb(1'b1, 8'h1c, 32'h00640001);
        tick_wait(1);
        ph_req <= 16'h012c;
        tick_wait(1);
        `CHK("inverse run", 2'b10, {start[1], trip[1]})
        tick_wait(1);
        `CHK("inverse trip", 3'b010, trip[2:0])
        ph_req <= 16'h0000;
        tick_wait(4);
    endtask
    task automatic t_tick_lost();
        stall <= 1'b1;
        repeat (60) @(posedge clk);
        `CHK("tick lost", 1'b1, tick_lost)
        stall <= 1'b0;
        tick_wait(1);
        apb(1'b1, 8'h60, 32'h1000);
        apb(1'b0, 8'h60, 32'h0);
        `CHK("lost cleared", 1'b0, rd[12])
        apb(1'b1, 8'h6c, 32'h000fffff);
        apb(1'b0, 8'h6c, 32'h0);
        `CHK("hold clamp", 32'h000927c0, rd)
    endtask
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_definite();
        t_block();
        t_hold();
        t_earth();
        t_inverse();
        t_tick_lost();
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end
endmodule // test_ovp_stages
`default_nettype wire
